// file: usbp_defines.svh
`ifndef USBP_DEFINES_SVH
`define USBP_DEFINES_SVH

// register byte offsets
`define USBP_OFS_OUT_EP1 8'h04
`define USBP_OFS_OUT_EP5 8'h14
`define USBP_OFS_IN_BASE 8'h18
`define USBP_OFS_IN_EP1 8'h1C
`define USBP_OFS_IN_EP5 8'h2C
`define USBP_OFS_ISO_BASE 8'h30
`define USBP_OFS_ISO_OUT 8'h34
`define USBP_OFS_ISO_IN 8'h38
`define USBP_OFS_ISO_SIZE 8'h3C
`define USBP_OFS_STATUS 8'h40

// reset value of every start setting
`define USBP_START_RST 8'h00

// buffer ram size in bytes and unit shifts
`define USBP_RAM_BYTES 12'h200
`define USBP_SH_BULK 1
`define USBP_SH_IN_BASE 2
`define USBP_SH_ISO_EP 2
`define USBP_SH_ISO_BASE 4

// highest bulk endpoint number
`define USBP_BULK_LAST 3'h5

`endif

// file: usbp_pkg.sv
package usbp_pkg;

	typedef enum logic [1:0]
	{
		USBP_BULK_OUT = 2'b00,
		USBP_BULK_IN = 2'b01,
		USBP_ISO_OUT = 2'b10,
		USBP_ISO_IN = 2'b11
	} usbp_region_t;

	typedef logic [7:0] usbp_start_t;

endpackage

// file: usbp_buf_part.sv
`timescale 1ns/1ps
`include "usbp_defines.svh"
module usbp_buf_part
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// endpoint engine buffer access
	input wire logic acc_valid,
	input wire logic acc_write,
	input wire usbp_pkg::usbp_region_t acc_region,
	input wire logic [2:0] acc_ep,
	input wire logic [8:0] acc_index,
	input wire logic [7:0] acc_wdata,
	output logic acc_done,
	output logic acc_err,
	output logic [8:0] acc_addr,
	output logic [7:0] acc_rdata
);

	logic [7:0] mem [0:511];

	usbp_pkg::usbp_start_t out_start [1:5];
	usbp_pkg::usbp_start_t in_start [1:5];
	usbp_pkg::usbp_start_t in_base;
	usbp_pkg::usbp_start_t iso_base;
	usbp_pkg::usbp_start_t iso_out_start;
	usbp_pkg::usbp_start_t iso_in_start;
	usbp_pkg::usbp_start_t iso_size;
	usbp_pkg::usbp_start_t next_out_start [1:5];
	usbp_pkg::usbp_start_t next_in_start [1:5];
	usbp_pkg::usbp_start_t next_in_base;
	usbp_pkg::usbp_start_t next_iso_base;
	usbp_pkg::usbp_start_t next_iso_out_start;
	usbp_pkg::usbp_start_t next_iso_in_start;
	usbp_pkg::usbp_start_t next_iso_size;

	logic wr_pend;
	logic [7:0] wr_addr;
	logic [31:0] rd_data;
	logic next_wr_pend;
	logic [7:0] next_wr_addr;
	logic [31:0] next_rd_data;
	logic err_sticky;
	logic next_err_sticky;
	logic [12:0] phys;
	logic bad;
	logic next_acc_done;
	logic next_acc_err;
	logic [8:0] next_acc_addr;

	// one bit of headroom so that a large base plus start cannot wrap below the bound
	function automatic logic [12:0] scale(input logic [7:0] v, input int sh);
		scale = 13'({5'h00, v} << sh);
	endfunction

	// start setting of a bulk endpoint, endpoint 0 fixed at zero
	function automatic logic [7:0] ep_start(input logic [2:0] ep, input logic is_in);
		ep_start = `USBP_START_RST;
		if (ep != 3'h0 && ep <= `USBP_BULK_LAST)
			ep_start = is_in ? in_start[ep] : out_start[ep];
	endfunction

	function automatic logic [31:0] reg_read(input logic [7:0] a);
		reg_read = 32'h0;
		if (a >= `USBP_OFS_OUT_EP1 && a <= `USBP_OFS_OUT_EP5 && a[1:0] == 2'h0)
			reg_read = {24'h0, out_start[3'(a[7:2] - 6'h0)]};
		else if (a >= `USBP_OFS_IN_EP1 && a <= `USBP_OFS_IN_EP5 && a[1:0] == 2'h0)
			reg_read = {24'h0, in_start[3'(a[7:2] - 6'h06)]};
		else
			case (a)
				`USBP_OFS_IN_BASE: reg_read = {24'h0, in_base};
				`USBP_OFS_ISO_BASE: reg_read = {24'h0, iso_base};
				`USBP_OFS_ISO_OUT: reg_read = {24'h0, iso_out_start};
				`USBP_OFS_ISO_IN: reg_read = {24'h0, iso_in_start};
				`USBP_OFS_ISO_SIZE: reg_read = {24'h0, iso_size};
				`USBP_OFS_STATUS: reg_read = {22'h0, acc_addr[8], err_sticky, acc_addr[7:0]};
				default: reg_read = 32'h0;
			endcase
	endfunction

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rd_data;

	// physical address of the current access
	always_comb
	begin
		phys = 13'h0000;
		bad = 1'b0;
		case (acc_region)
			usbp_pkg::USBP_BULK_OUT:
			begin
				phys = scale(ep_start(acc_ep, 1'b0), `USBP_SH_BULK) + {4'h0, acc_index};
				bad = acc_ep > `USBP_BULK_LAST;
			end
			usbp_pkg::USBP_BULK_IN:
			begin
				phys = scale(in_base, `USBP_SH_IN_BASE)
					+ scale(ep_start(acc_ep, 1'b1), `USBP_SH_BULK) + {4'h0, acc_index};
				bad = acc_ep > `USBP_BULK_LAST;
			end
			usbp_pkg::USBP_ISO_OUT:
				phys = scale(iso_base, `USBP_SH_ISO_BASE)
					+ scale(iso_out_start, `USBP_SH_ISO_EP) + {4'h0, acc_index};
			default:
				phys = scale(iso_base, `USBP_SH_ISO_BASE)
					+ scale(iso_in_start, `USBP_SH_ISO_EP) + {4'h0, acc_index};
		endcase
		if (acc_region[1] && phys >= scale(iso_base, `USBP_SH_ISO_BASE)
			+ scale(iso_size, `USBP_SH_ISO_BASE))
			bad = 1'b1;
		if (phys >= `USBP_RAM_BYTES)
			bad = 1'b1;
	end

	always_comb
	begin
		next_acc_done = acc_valid;
		next_acc_err = acc_valid & bad;
		next_acc_addr = acc_valid ? phys[8:0] : acc_addr;
		next_wr_pend = hsel & htrans[1] & hready & hwrite;
		next_wr_addr = (hsel & htrans[1] & hready) ? haddr : wr_addr;
		next_rd_data = rd_data;
		if (hsel & htrans[1] & hready & ~hwrite)
		begin
			next_rd_data = reg_read(haddr);
			// forward only plain settings; status and holes keep their own read value
			if (wr_pend && wr_addr == haddr && haddr[1:0] == 2'h0
				&& haddr >= `USBP_OFS_OUT_EP1 && haddr <= `USBP_OFS_ISO_SIZE)
				next_rd_data = {24'h0, hwdata[7:0]};
		end
		next_out_start = out_start;
		next_in_start = in_start;
		next_in_base = in_base;
		next_iso_base = iso_base;
		next_iso_out_start = iso_out_start;
		next_iso_in_start = iso_in_start;
		next_iso_size = iso_size;
		next_err_sticky = err_sticky;
		if (wr_pend && wr_addr[1:0] == 2'h0)
		begin
			if (wr_addr >= `USBP_OFS_OUT_EP1 && wr_addr <= `USBP_OFS_OUT_EP5)
				next_out_start[3'(wr_addr[7:2])] = hwdata[7:0];
			else if (wr_addr >= `USBP_OFS_IN_EP1 && wr_addr <= `USBP_OFS_IN_EP5)
				next_in_start[3'(wr_addr[7:2] - 6'h06)] = hwdata[7:0];
			else
				case (wr_addr)
					`USBP_OFS_IN_BASE: next_in_base = hwdata[7:0];
					`USBP_OFS_ISO_BASE: next_iso_base = hwdata[7:0];
					`USBP_OFS_ISO_OUT: next_iso_out_start = hwdata[7:0];
					`USBP_OFS_ISO_IN: next_iso_in_start = hwdata[7:0];
					`USBP_OFS_ISO_SIZE: next_iso_size = hwdata[7:0];
					`USBP_OFS_STATUS: next_err_sticky = err_sticky & ~hwdata[8];
					default: next_err_sticky = err_sticky;
				endcase
		end
		// a new refusal wins over a clear in the same cycle
		if (acc_valid & bad)
			next_err_sticky = 1'b1;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 1; i <= 5; i++)
			begin
				out_start[i] <= `USBP_START_RST;
				in_start[i] <= `USBP_START_RST;
			end
			in_base <= `USBP_START_RST;
			iso_base <= `USBP_START_RST;
			iso_out_start <= `USBP_START_RST;
			iso_in_start <= `USBP_START_RST;
			iso_size <= `USBP_START_RST;
			err_sticky <= 1'b0;
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			rd_data <= 32'h0000_0000;
			acc_done <= 1'b0;
			acc_err <= 1'b0;
			acc_addr <= 9'h000;
		end
		else
		begin
			out_start <= next_out_start;
			in_start <= next_in_start;
			in_base <= next_in_base;
			iso_base <= next_iso_base;
			iso_out_start <= next_iso_out_start;
			iso_in_start <= next_iso_in_start;
			iso_size <= next_iso_size;
			err_sticky <= next_err_sticky;
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			rd_data <= next_rd_data;
			acc_done <= next_acc_done;
			acc_err <= next_acc_err;
			acc_addr <= next_acc_addr;
		end
	end

	// buffer ram, refused accesses leave it untouched
	always_ff @(posedge mclk)
	begin
		if (acc_valid && acc_write && !bad)
			mem[phys[8:0]] <= acc_wdata;
		if (acc_valid)
			acc_rdata <= mem[phys[8:0]];
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_req(usbp_pkg::usbp_region_t r);
		acc_valid && acc_region == r;
	endsequence

	a_ram_bound: assert property (acc_done && !acc_err |-> $past(phys) < `USBP_RAM_BYTES
		&& acc_addr == $past(phys[8:0])) else $error("access above buffer ram");
	a_ep0_out_zero: assert property (s_req(usbp_pkg::USBP_BULK_OUT) ##0 acc_ep == 3'h0
		|=> acc_done && acc_addr == $past(acc_index)) else $error("ep0 out not at zero");
	a_bulk_in_addr: assert property (s_req(usbp_pkg::USBP_BULK_IN) ##0 acc_ep == 3'h0
		|=> acc_addr == 9'($past(in_base) * 4 + $past(acc_index))) else $error("in addr");
	a_in_base_scale: assert property (s_req(usbp_pkg::USBP_BULK_IN) ##0 acc_ep == 3'h0
		|=> acc_addr[1:0] == $past(acc_index[1:0]))
		else $error("in base not 4-byte units");
	a_iso_out_addr: assert property (s_req(usbp_pkg::USBP_ISO_OUT) ##0 iso_out_start == 8'h00
		|=> acc_addr == 9'($past(iso_base) * 16 + $past(acc_index)))
		else $error("iso base not 16-byte units");
	a_iso_out_write: assert property (wr_pend && wr_addr == `USBP_OFS_ISO_OUT
		|=> iso_out_start == $past(hwdata[7:0])) else $error("iso out start not written");
	a_iso_in_addr: assert property (s_req(usbp_pkg::USBP_ISO_IN)
		|=> acc_addr == 9'($past(iso_base) * 16 + $past(iso_in_start) * 4 + $past(acc_index)))
		else $error("iso in addr");
	a_iso_size_err: assert property (s_req(usbp_pkg::USBP_ISO_IN)
		##0 13'(acc_index) + 13'(iso_in_start) * 13'h0004 >= 13'(iso_size) * 13'h0010
		|=> acc_done && acc_err && err_sticky) else $error("iso size not enforced");
	a_one_cycle: assert property (acc_valid |=> acc_done ##1 (acc_done == $past(acc_valid)))
		else $error("access not answered next cycle");

endmodule

// file: usbp_eng_model.sv
`timescale 1ns/1ps
module usbp_eng_model
(
	// clock
	input wire logic mclk,
	// buffer access
	output logic acc_valid,
	output logic acc_write,
	output usbp_pkg::usbp_region_t acc_region,
	output logic [2:0] acc_ep,
	output logic [8:0] acc_index,
	output logic [7:0] acc_wdata,
	input wire logic acc_done,
	input wire logic acc_err,
	input wire logic [8:0] acc_addr,
	input wire logic [7:0] acc_rdata
);
	initial
	begin
		acc_valid = 1'h0;
		acc_write = 1'h0;
		acc_region = usbp_pkg::USBP_BULK_OUT;
		acc_ep = 3'h0;
		acc_index = 9'h000;
		acc_wdata = 8'h00;
	end

	// one byte access, waits for the registered answer
	task automatic access(input logic [1:0] rg, input logic [2:0] ep, input logic [8:0] ix,
		input logic wr, input logic [7:0] wd, output logic [8:0] ad, output logic er,
		output logic [7:0] rd);
		int n;
		@(posedge mclk);
		acc_valid <= 1'h1;
		acc_write <= wr;
		acc_region <= usbp_pkg::usbp_region_t'(rg);
		acc_ep <= ep;
		acc_index <= ix;
		acc_wdata <= wd;
		@(posedge mclk);
		acc_valid <= 1'h0;
		// released index and data lines show no stale value
		acc_index <= ~ix;
		acc_wdata <= ~wd;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (acc_done !== 1'h1 && n < 8);
		ad = acc_addr;
		er = acc_err;
		rd = acc_rdata;
	endtask
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic mclk, rst_n, hsel, hwrite, hreadyout, hresp, er;
	logic acc_valid, acc_write, acc_done, acc_err;
	logic [7:0] haddr, acc_wdata, acc_rdata, rd;
	logic [1:0] htrans;
	logic [31:0] hwdata, hrdata, rv;
	logic [2:0] acc_ep;
	logic [8:0] acc_index, acc_addr, ad;
	usbp_pkg::usbp_region_t acc_region;
	int n_fail, n_tests, cyc;
	// six 32-byte bulk pairs, two 32-byte iso buffers
	logic [7:0] cfg [0:14] = '{8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h30, 8'h10, 8'h20,
		8'h30, 8'h40, 8'h50, 8'h18, 8'h00, 8'h08, 8'h04};
	logic [1:0] t_rg [0:6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h3, 2'h0};
	logic [2:0] t_ep [0:6] = '{3'h1, 3'h2, 3'h0, 3'h0, 3'h0, 3'h0, 3'h6};
	logic [8:0] t_ix [0:6] = '{9'h003, 9'h007, 9'h001, 9'h005, 9'h01F, 9'h020, 9'h000};
	logic [8:0] t_ad [0:6] = '{9'h023, 9'h107, 9'h0C1, 9'h185, 9'h1BF, 9'h000, 9'h000};
	logic t_er [0:6] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1};

	initial
	begin
		mclk = 1'h0;
		forever #50 mclk = ~mclk;
	end

	usbp_buf_part dut_u (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .acc_valid(acc_valid),
		.acc_write(acc_write), .acc_region(acc_region), .acc_ep(acc_ep),
		.acc_index(acc_index), .acc_wdata(acc_wdata), .acc_done(acc_done),
		.acc_err(acc_err), .acc_addr(acc_addr), .acc_rdata(acc_rdata));

	usbp_eng_model eng_u (.mclk(mclk), .acc_valid(acc_valid), .acc_write(acc_write),
		.acc_region(acc_region), .acc_ep(acc_ep), .acc_index(acc_index),
		.acc_wdata(acc_wdata), .acc_done(acc_done), .acc_err(acc_err),
		.acc_addr(acc_addr), .acc_rdata(acc_rdata));

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: %s got %0h expected %0h", $time, msg, got, exp);
		end
	endtask

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		@(posedge mclk);
		hsel <= 1'h1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (hreadyout !== 1'h1 && n < 64);
		htrans <= 2'h0;
		hwdata <= d;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (hreadyout !== 1'h1 && n < 64);
		r = hrdata;
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			$display("Error at %0t: timeout", $time);
			n_fail++;
			finish_test();
		end
	end

	initial
	begin
		rst_n = 1'h0;
		hsel = 1'h0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'h0;
		hwdata = 32'h0;
		cyc = 0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'h1;
		for (int i = 0; i < 15; i++)
		begin
			ahb(1'h0, 8'h04 + 8'(4 * i), 32'h0, rv);
			check(rv, 32'h0, "reset value");
			ahb(1'h1, 8'h04 + 8'(4 * i), {24'hFFFFFF, cfg[i]}, rv);
		end
		ahb(1'h0, 8'h44, 32'h0, rv);
		check(rv, 32'h0, "unmapped read");
		check(hresp, 1'h0, "bus response");
		for (int i = 0; i < 15; i++)
		begin
			ahb(1'h0, 8'h04 + 8'(4 * i), 32'h0, rv);
			check(rv, {24'h0, cfg[i]}, "setting readback");
		end
		for (int i = 0; i < 7; i++)
		begin
			eng_u.access(t_rg[i], t_ep[i], t_ix[i], 1'h0, 8'h00, ad, er, rd);
			check(acc_done, 1'h1, "answer pulse");
			check(er, t_er[i], "refusal");
			if (!t_er[i])
				check(ad, t_ad[i], "physical address");
		end
		eng_u.access(2'h0, 3'h1, 9'h003, 1'h1, 8'h5A, ad, er, rd);
		eng_u.access(2'h0, 3'h1, 9'h003, 1'h1, 8'hA5, ad, er, rd);
		check(rd, 8'h5A, "old byte on write");
		eng_u.access(2'h0, 3'h1, 9'h003, 1'h0, 8'h00, ad, er, rd);
		check(rd, 8'hA5, "byte readback");
		ahb(1'h1, 8'h14, 32'hFF, rv);
		eng_u.access(2'h0, 3'h5, 9'h002, 1'h1, 8'h11, ad, er, rd);
		check(er, 1'h1, "beyond 512 bytes");
		eng_u.access(2'h0, 3'h5, 9'h001, 1'h0, 8'h00, ad, er, rd);
		check({er, ad}, {1'h0, 9'h1FF}, "last byte");
		ahb(1'h0, 8'h40, 32'h0, rv);
		check(rv[9:0], 10'h3FF, "sticky error");
		ahb(1'h1, 8'h40, 32'h100, rv);
		ahb(1'h0, 8'h40, 32'h0, rv);
		check(rv[9:0], 10'h2FF, "sticky cleared");
		finish_test();
	end
endmodule
